// ---- tcm_pkg.sv ----
// Constants, register map and state type for the modulo timer counter
package tcm_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] CNT_HI_OFS = 8'h00;  // Count high byte, read-only
  localparam logic [7:0] CNT_LO_OFS = 8'h04;  // Count low byte, read-only
  localparam logic [7:0] LIM_HI_OFS = 8'h08;  // Wrap limit high byte
  localparam logic [7:0] LIM_LO_OFS = 8'h0c;  // Wrap limit low byte
  localparam logic [7:0] CTRL_OFS   = 8'h10;  // Control and status

  // ****************************************************************
  // Control and status fields
  // ****************************************************************
  localparam int unsigned CTRL_CLR_BIT = 0;  // Write one: clear the count
  localparam int unsigned CTRL_IE_BIT  = 1;  // Overflow interrupt enable
  localparam int unsigned CTRL_OVF_BIT = 7;  // Overflow flag, write one clears

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [15:0] CNT_RST     = 16'h0000;  // Count after reset
  localparam logic [15:0] LIM_RST     = 16'hffff;  // Largest wrap limit
  localparam logic [1:0]  RESP_OKAY   = 2'h0;      // Normal answer
  localparam logic [1:0]  RESP_SLVERR = 2'h2;      // Unmapped address

  // One-hot register select
  typedef enum logic [5:0] {
    TCM_SEL_NONE = 6'h01,
    TCM_SEL_CHI  = 6'h02,
    TCM_SEL_CLO  = 6'h04,
    TCM_SEL_LHI  = 6'h08,
    TCM_SEL_LLO  = 6'h10,
    TCM_SEL_CTRL = 6'h20
  } tcm_sel_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cnt;      // Running count
    logic [15:0] lim;      // Wrap limit
    logic [7:0]  lbuf;     // Captured low byte
    logic        latched;  // Low byte capture pending
    logic        ovf;      // Overflow flag
    logic        ie;       // Overflow interrupt enable
    logic        inhib;    // Flag held off after a high limit write
    logic        irq;      // Interrupt request output
    logic        aw_have;  // Write address held
    logic        w_have;   // Write data held
    logic [7:0]  aw_addr;  // Held write address
    logic [7:0]  wdata;    // Held write data, low lane
    logic        wstb;     // Low lane strobe
    logic        awready;  // AXI handshake flops
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } tcm_state_t;

endpackage : tcm_pkg

// ---- tcm_timer.sv ----
// Modulo timer counter with an AXI4-Lite register slave
//
// Functional notes
// - Count readable as two read-only bytes
// - High byte read captures the low byte
// - Capture held until low byte read
// - Reset clears both count bytes
// - Clear bit zeroes the count
// - Wrap limit held in two writable bytes
// - Count equal to limit sets overflow flag
// - After the limit, count restarts at zero
// - High limit write blocks flag until low
// - Reset sets wrap limit to all ones
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module tcm_timer #(
  parameter int unsigned AW = 8  // AXI address width
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               ovf_irq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Shared by the read and the write path
  function automatic tcm_pkg::tcm_sel_t reg_sel(input logic [7:0] a);
    case (a)
      tcm_pkg::CNT_HI_OFS: reg_sel = tcm_pkg::TCM_SEL_CHI;
      tcm_pkg::CNT_LO_OFS: reg_sel = tcm_pkg::TCM_SEL_CLO;
      tcm_pkg::LIM_HI_OFS: reg_sel = tcm_pkg::TCM_SEL_LHI;
      tcm_pkg::LIM_LO_OFS: reg_sel = tcm_pkg::TCM_SEL_LLO;
      tcm_pkg::CTRL_OFS:   reg_sel = tcm_pkg::TCM_SEL_CTRL;
      default:             reg_sel = tcm_pkg::TCM_SEL_NONE;
    endcase
  endfunction : reg_sel

  tcm_pkg::tcm_state_t s_r;      // Registered state
  tcm_pkg::tcm_state_t s_nxt;    // Next state
  tcm_pkg::tcm_sel_t   wsel;     // Decoded write target
  tcm_pkg::tcm_sel_t   rsel;     // Decoded read target
  logic                wr_go;    // Held write executes now
  logic                rd_hi;    // Count high byte read taken
  logic                rd_lo;    // Count low byte read taken
  logic                clr_evt;  // Software count clear
  logic                wrap;     // Count sits on the limit

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_nxt   = s_r;
    wsel    = reg_sel(s_r.aw_addr);
    rsel    = reg_sel(s_axi_araddr[7:0]);
    wr_go   = s_r.aw_have && s_r.w_have && !s_r.bvalid;
    rd_hi   = 1'b0;
    rd_lo   = 1'b0;
    clr_evt = 1'b0;
    wrap    = (s_r.cnt == s_r.lim);

    // Counting; one step per clock edge
    if (wrap) begin
      s_nxt.cnt = tcm_pkg::CNT_RST;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end

    // Write channel capture, address and data in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = s_axi_wdata[7:0];
      s_nxt.wstb   = s_axi_wstrb[0];
    end

    // Register write once both halves are held
    if (wr_go) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = tcm_pkg::RESP_OKAY;
      case (wsel)
        tcm_pkg::TCM_SEL_CHI, tcm_pkg::TCM_SEL_CLO: begin
          // Count bytes ignore writes but answer OKAY
        end
        tcm_pkg::TCM_SEL_LHI: begin
          if (s_r.wstb) begin
            s_nxt.lim[15:8] = s_r.wdata;
            s_nxt.inhib     = 1'b1;
          end
        end
        tcm_pkg::TCM_SEL_LLO: begin
          if (s_r.wstb) begin
            s_nxt.lim[7:0] = s_r.wdata;
            s_nxt.inhib    = 1'b0;
          end
        end
        tcm_pkg::TCM_SEL_CTRL: begin
          if (s_r.wstb) begin
            s_nxt.ie = s_r.wdata[tcm_pkg::CTRL_IE_BIT];
            clr_evt  = s_r.wdata[tcm_pkg::CTRL_CLR_BIT];
            if (s_r.wdata[tcm_pkg::CTRL_OVF_BIT]) begin
              s_nxt.ovf = 1'b0;
            end
          end
        end
        default: begin
          s_nxt.bresp = tcm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Clear overrides both advance and wrap
    if (clr_evt) begin
      s_nxt.cnt = tcm_pkg::CNT_RST;
    end

    // Flag set placed after the clear so a same-cycle event survives
    if (wrap && !s_r.inhib) begin
      s_nxt.ovf = 1'b1;
    end

    // Read channel; side effects act at the address handshake
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = tcm_pkg::RESP_OKAY;
      case (rsel)
        tcm_pkg::TCM_SEL_CHI: begin
          rd_hi       = 1'b1;
          s_nxt.rdata = s_r.cnt[15:8];
          if (!s_r.latched) begin
            s_nxt.lbuf    = s_r.cnt[7:0];
            s_nxt.latched = 1'b1;
          end
        end
        tcm_pkg::TCM_SEL_CLO: begin
          rd_lo         = 1'b1;
          s_nxt.rdata   = s_r.latched ? s_r.lbuf : s_r.cnt[7:0];
          s_nxt.latched = 1'b0;
        end
        tcm_pkg::TCM_SEL_LHI: begin
          s_nxt.rdata = s_r.lim[15:8];
        end
        tcm_pkg::TCM_SEL_LLO: begin
          s_nxt.rdata = s_r.lim[7:0];
        end
        tcm_pkg::TCM_SEL_CTRL: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rdata[tcm_pkg::CTRL_IE_BIT]  = s_r.ie;
          s_nxt.rdata[tcm_pkg::CTRL_OVF_BIT] = s_r.ovf;
        end
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = tcm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Ready flops: one transaction of each kind at a time
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;

    // Registered request, so the pin is glitch free
    s_nxt.irq = s_nxt.ovf && s_nxt.ie;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r     <= '0;
      s_r.cnt <= tcm_pkg::CNT_RST;
      s_r.lim <= tcm_pkg::LIM_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state flops
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h000000, s_r.rdata};
  assign ovf_irq       = s_r.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence at_limit_s;
    (s_r.cnt == s_r.lim) && !clr_evt;
  endsequence

  sequence fresh_capture_s;
    rd_hi && !s_r.latched;
  endsequence

  wrap_to_zero_a: assert property (at_limit_s |=> s_r.cnt == 16'h0000)
    else $error("count did not wrap to zero");

  count_step_a: assert property (
    (s_r.cnt != s_r.lim) && !clr_evt |=> s_r.cnt == $past(s_r.cnt) + 16'h0001)
    else $error("count did not advance by one");

  flag_set_a: assert property (at_limit_s ##0 !s_r.inhib |=> s_r.ovf)
    else $error("overflow flag not set at limit");

  flag_blocked_a: assert property (s_r.inhib |=> !$rose(s_r.ovf))
    else $error("overflow flag set while held off");

  capture_take_a: assert property (
    fresh_capture_s |=> s_r.latched && s_r.lbuf == $past(s_r.cnt[7:0]))
    else $error("low byte not captured on high read");

  capture_hold_a: assert property (
    s_r.latched && !rd_lo |=> s_r.latched && $stable(s_r.lbuf))
    else $error("captured low byte changed");

  capture_read_a: assert property (
    fresh_capture_s ##1 (!rd_lo && !rd_hi) [*1] ##1 rd_lo
      |=> s_axi_rdata[7:0] == $past(s_r.lbuf))
    else $error("low read did not return captured byte");

  clear_count_a: assert property (clr_evt |=> s_r.cnt == 16'h0000)
    else $error("count clear failed");

  irq_follow_a: assert property (ovf_irq == (s_r.ovf && s_r.ie))
    else $error("interrupt does not follow flag and enable");

  reset_vals_a: assert property (
    disable iff (1'b0) !aresetn |=> s_r.cnt == 16'h0000 && s_r.lim == 16'hffff)
    else $error("reset values wrong");

  // Answers must stand until the master takes them, or a slow master loses data
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed before it was taken");

  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer changed before it was taken");

  // Limit byte writes as they execute, strobe lane enabled
  sequence high_limit_write_s;
    wr_go && s_r.wstb && (wsel == tcm_pkg::TCM_SEL_LHI);
  endsequence

  sequence low_limit_write_s;
    wr_go && s_r.wstb && (wsel == tcm_pkg::TCM_SEL_LLO);
  endsequence

  // High byte lands and starts the hold-off
  limit_high_a: assert property (
    high_limit_write_s |=> s_r.inhib && s_r.lim[15:8] == $past(s_r.wdata))
    else $error("high limit write not taken");

  // Low byte lands and ends the hold-off
  hold_release_a: assert property (
    low_limit_write_s |=> !s_r.inhib && s_r.lim[7:0] == $past(s_r.wdata))
    else $error("low limit write did not release hold-off");

endmodule : tcm_timer

`default_nettype wire

// ---- test_timer_counter_modulo_core.sv ----
// Self-checking bench for the modulo timer counter register slave
`timescale 1ns/10ps
`default_nettype none

module test_timer_counter_modulo_core;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic        aclk;                          // 40 MHz bus clock
  logic        aresetn;                       // Synchronous reset, low
  logic [7:0]  s_axi_awaddr, s_axi_araddr;    // Byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;      // Data lanes
  logic [3:0]  s_axi_wstrb;                   // All lanes enabled
  logic [1:0]  s_axi_bresp, s_axi_rresp;      // Answer codes
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ovf_irq;
  int          errors, total_checks, seed;    // Score and random seed
  int          lim, ie;                       // Random limit and enable
  logic [31:0] rd;                            // Last read data
  logic [1:0]  rs;                            // Last answer code
  logic [15:0] c1, c2;                        // Count snapshots

  tcm_timer uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ovf_irq(ovf_irq));

  // Free-running clock, 25 ns period
  always #12.5 aclk = ~aclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Expected control word from the flag and enable fields
  function automatic logic [31:0] ctrl_word(input logic ovf, input logic ien);
    ctrl_word = 32'h00000000;
    ctrl_word[tcm_pkg::CTRL_OVF_BIT] = ovf;
    ctrl_word[tcm_pkg::CTRL_IE_BIT]  = ien;
  endfunction : ctrl_word

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Exact comparison; unknowns never match
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Range comparison for counts whose exact phase is not pinned down
  task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
    total_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      errors++;
      $display("ERROR %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng

  // Bounded wait guard, a hung handshake ends the run
  task automatic tmo(input int n);
    if (n > 200) begin
      errors++;
      $display("ERROR handshake expected answer seen none");
      conclude();
    end
  endtask : tmo

  // Write: address and data offered together, each dropped once taken
  // Response ready stays high afterwards, so it never toggles within one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    bit dn;
    n = 0;
    dn = 0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        dn = 1;
      end
      n++;
      tmo(n);
    end
  endtask : wr

  // Read: address held until taken, data taken at the rvalid edge
  // Read ready stays high afterwards, for the same reason as on writes
  task automatic rdr(input logic [7:0] a);
    int n;
    bit dn;
    n = 0;
    dn = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        dn = 1;
      end
      n++;
      tmo(n);
    end
  endtask : rdr

  // High byte first, so the low byte comes from the capture
  task automatic rcnt(output logic [15:0] v);
    rdr(tcm_pkg::CNT_HI_OFS);
    v[15:8] = rd[7:0];
    rdr(tcm_pkg::CNT_LO_OFS);
    v[7:0] = rd[7:0];
  endtask : rcnt

  // Main sequence
  initial begin
    seed = 32'hc129;
    errors = 0;
    total_checks = 0;
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(tcm_pkg::LIM_HI_OFS);
    chk("lim_hi_rst", 32'h000000ff, rd);
    rdr(tcm_pkg::LIM_LO_OFS);
    chk("lim_lo_rst", 32'h000000ff, rd);
    rdr(tcm_pkg::CTRL_OFS);
    chk("ctrl_rst", ctrl_word(1'b0, 1'b0), rd);
    rcnt(c1);
    chk_rng("cnt_rst", 0, 40, c1);
    rdr(8'h14);
    chk("bad_rresp", tcm_pkg::RESP_SLVERR, rs);
    chk("bad_rdata", 32'h00000000, rd);
    wr(8'h1c, 8'h5a);
    chk("bad_bresp", tcm_pkg::RESP_SLVERR, rs);
    wr(tcm_pkg::CNT_HI_OFS, 8'h55);
    chk("ro_bresp", tcm_pkg::RESP_OKAY, rs);
    rdr(tcm_pkg::CNT_HI_OFS);
    chk("ro_cnt_hi", 32'h00000000, rd);
    // Release the capture that the high read just took
    rdr(tcm_pkg::CNT_LO_OFS);
    $display("test reset and map done");
    // A second high read while captured must not recapture
    wr(tcm_pkg::CTRL_OFS, 8'h01);
    repeat (100) @(posedge aclk);
    rdr(tcm_pkg::CNT_HI_OFS);
    c1[15:8] = rd[7:0];
    repeat (150) @(posedge aclk);
    rdr(tcm_pkg::CNT_HI_OFS);
    repeat (150) @(posedge aclk);
    rdr(tcm_pkg::CNT_LO_OFS);
    c1[7:0] = rd[7:0];
    rcnt(c2);
    chk_rng("latch_gap", 300, 330, 32'(c2 - c1));
    wr(tcm_pkg::CTRL_OFS, 8'h01);
    rcnt(c1);
    chk_rng("clr_cnt", 0, 12, c1);
    $display("test capture and clear done");
    // Random small limits, enable on or off
    for (int i = 0; i < 4; i++) begin
      lim = 16 + ($random(seed) & 31);
      ie = $random(seed) & 1;
      wr(tcm_pkg::CTRL_OFS, 8'h01);
      wr(tcm_pkg::LIM_HI_OFS, 8'h00);
      wr(tcm_pkg::LIM_LO_OFS, lim[7:0]);
      wr(tcm_pkg::CTRL_OFS, 8'(ctrl_word(1'b1, ie[0])));
      repeat (2 * lim) @(posedge aclk);
      rdr(tcm_pkg::LIM_LO_OFS);
      chk("lim_lo_rw", lim, rd);
      rcnt(c1);
      chk_rng("wrap_cnt", 0, lim, c1);
      rdr(tcm_pkg::CTRL_OFS);
      chk("ovf_set", ctrl_word(1'b1, ie[0]), rd);
      chk("irq", ie[0], ovf_irq);
    end
    $display("test random limits done");
    // Flag held off between the high and the low limit writes
    wr(tcm_pkg::CTRL_OFS, 8'h01);
    wr(tcm_pkg::LIM_HI_OFS, 8'h00);
    wr(tcm_pkg::CTRL_OFS, 8'h82);
    repeat (120) @(posedge aclk);
    rdr(tcm_pkg::CTRL_OFS);
    chk("ovf_held", ctrl_word(1'b0, 1'b1), rd);
    chk("irq_held", 1'b0, ovf_irq);
    // Clear again so the new low limit lies ahead of the count
    wr(tcm_pkg::CTRL_OFS, 8'h03);
    wr(tcm_pkg::LIM_LO_OFS, 8'h14);
    repeat (60) @(posedge aclk);
    rdr(tcm_pkg::CTRL_OFS);
    chk("ovf_free", ctrl_word(1'b1, 1'b1), rd);
    chk("irq_on", 1'b1, ovf_irq);
    $display("test hold-off done");
    conclude();
  end
endmodule : test_timer_counter_modulo_core

`default_nettype wire
